// ==== dv/rwc_core_model.sv ====
/* core-side model: restart instruction and dog vector entry as pulses.
   assumes tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module rwc_core_model (
  input wire logic clk,
  output logic dog_restart,
  output logic dog_irq_ack
);
  // ==========
  // idle until the bench asks for an instruction
  initial begin
    dog_restart = 1'b0;
    dog_irq_ack = 1'b0;
  end
  // restart instruction lasts one cycle; software must issue it in time
  task restart;
    dog_restart <= 1'b1;
    @(posedge clk);
    dog_restart <= 1'b0;
  endtask : restart
  // entering the dog vector clears the request flag
  task ack;
    dog_irq_ack <= 1'b1;
    @(posedge clk);
    dog_irq_ack <= 1'b0;
  endtask : ack
endmodule : rwc_core_model

// ==== dv/rwc_reset_ctrl_bench.sv ====
/* self-checking bench of the reset and watchdog controller.
   assumes the core model and the checker are compiled first. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module rwc_reset_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, power_ok = 1'b0, pin_reset_n = 1'b1;
  logic low_supply_ok = 1'b1, pin_reset_disable_fuse = 1'b0, dog_always_on_fuse = 1'b0;
  logic dog_osc_tick = 1'b0, osc_on = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [2:0] low_supply_level_fuse = 3'h0;
  logic [3:0] startup_time_fuse = 4'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, port_reset, core_reset, dog_irq, bandgap_enable;
  logic dog_restart, dog_irq_ack;
  int errors = 0, checks = 0, cycles = 0;
  // ==========
  // core model and controller
  rwc_core_model core (.clk, .dog_restart, .dog_irq_ack);
  rwc_reset_ctrl DUT (.clk, .rst, .power_ok, .pin_reset_n, .low_supply_ok,
    .pin_reset_disable_fuse, .low_supply_level_fuse, .startup_time_fuse,
    .dog_always_on_fuse, .dog_osc_tick, .dog_restart, .dog_irq_ack, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .port_reset, .core_reset, .dog_irq, .bandgap_enable);
  always #4 clk = ~clk;
  // dog oscillator far faster than real to keep expiries short; run limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (osc_on && cycles[0]) begin
      dog_osc_tick <= ~dog_osc_tick;
    end
    if (cycles == 60000) begin
      errors++;
      complete_run();
    end
  end
  task complete_run;
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // ==========
  // one single ahb-lite transfer, address phase then data phase
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask : rd
  // bounded wait for core_reset (k 0) or dog_irq (k 1) to reach v, then compare
  task automatic hold(input int k, input logic v);
    repeat (10000) if ((k == 0 ? core_reset : dog_irq) !== v) @(posedge clk);
    `CHK(k == 0 ? core_reset : dog_irq, v)
  endtask : hold
  // drop source k (0 power, 1 pin, 2 low supply) for eight cycles, then wait out the stretch
  task automatic blip(input int k);
    if (k == 0) power_ok <= 1'b0;
    else if (k == 1) pin_reset_n <= 1'b0;
    else low_supply_ok <= 1'b0;
    repeat (8) @(posedge clk);
    power_ok <= 1'b1;
    pin_reset_n <= 1'b1;
    low_supply_ok <= 1'b1;
    hold(0, 1'b0);
  endtask : blip
  // ==========
  // sources and status, then bandgap, unlock and the three dog modes
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    power_ok <= 1'b1;
    hold(0, 1'b0);
    rd(12'h000, 32'h1);
    wr(12'h000, 32'hff);
    rd(12'h000, 32'h1);
    blip(1);
    rd(12'h000, 32'h3);
    wr(12'h000, 32'h0);
    rd(12'h000, 32'h0);
    // a larger start-up code must still hold the core where code 0 has let go
    startup_time_fuse <= 4'h1;
    pin_reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    pin_reset_n <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK(core_reset, 1'b1)
    hold(0, 1'b0);
    startup_time_fuse <= 4'h0;
    wr(12'h000, 32'h0);
    pin_reset_disable_fuse <= 1'b1;
    pin_reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    `CHK(port_reset, 1'b0)
    pin_reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    pin_reset_disable_fuse <= 1'b0;
    low_supply_level_fuse <= 3'h1;
    blip(2);
    `CHK(bandgap_enable, 1'b1)
    rd(12'h000, 32'h4);
    blip(1);
    rd(12'h000, 32'h6);
    low_supply_level_fuse <= 3'h0;
    blip(0);
    rd(12'h000, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(12'h008, 32'(i));
      repeat (2) @(posedge clk);
      `CHK(bandgap_enable, i != 0)
    end
    wr(12'h004, 32'h8);
    rd(12'h004, 32'h8);
    wr(12'h004, 32'h0);
    rd(12'h004, 32'h8);
    wr(12'h004, 32'h18);
    wr(12'h004, 32'h0);
    rd(12'h004, 32'h0);
    wr(12'h004, 32'h18);
    repeat (6) @(posedge clk);
    rd(12'h004, 32'h8);
    wr(12'h004, 32'h0);
    rd(12'h004, 32'h8);
    wr(12'h004, 32'h18);
    wr(12'h004, 32'h40);
    osc_on <= 1'b1;
    hold(1, 1'b1);
    `CHK(port_reset, 1'b0)
    rd(12'h004, 32'hc0);
    core.ack();
    repeat (2) @(posedge clk);
    `CHK(dog_irq, 1'b0)
    repeat (6000) @(posedge clk);
    core.restart();
    repeat (6000) @(posedge clk);
    `CHK(dog_irq, 1'b0)
    wr(12'h004, 32'h48);
    core.restart();
    repeat (9000) @(posedge clk);
    rd(12'h004, 32'h88);
    `CHK(dog_irq, 1'b1)
    hold(0, 1'b1);
    osc_on <= 1'b0;
    hold(0, 1'b0);
    rd(12'h000, 32'h9);
    rd(12'h004, 32'h8);
    wr(12'h000, 32'h0);
    rd(12'h000, 32'h0);
    dog_always_on_fuse <= 1'b1;
    wr(12'h004, 32'h40);
    rd(12'h004, 32'h8);
    complete_run();
  end
endmodule : rwc_reset_ctrl_bench

// ==== dv/rwc_reset_ctrl_properties.sv ====
/* port assertions of the reset and watchdog controller.
   assumes a bind onto every rwc_reset_ctrl instance. */
`timescale 1ns/1ps
module rwc_reset_ctrl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic power_ok,
  input wire logic pin_reset_n,
  input wire logic low_supply_ok,
  input wire logic pin_reset_disable_fuse,
  input wire logic [2:0] low_supply_level_fuse,
  input wire logic [3:0] startup_time_fuse,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic port_reset,
  input wire logic core_reset,
  input wire logic dog_irq,
  input wire logic bandgap_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] calm;
  logic [7:0] quiet;
  logic rd_status;
  // ==========
  // helpers: calm counts cycles with no analog or pin source, so a reset
  // rising then can only be the dog pulse
  always_ff @(posedge clk) begin
    if (rst || !(power_ok && (pin_reset_n || pin_reset_disable_fuse)
        && (low_supply_ok || low_supply_level_fuse == 3'h0))) begin
      calm <= 5'h00;
    end else if (calm != 5'h1f) begin
      calm <= calm + 5'h01;
    end
  end
  // cycles since the last source was seen
  always_ff @(posedge clk) begin
    if (rst || port_reset) begin
      quiet <= 8'h00;
    end else if (quiet != 8'hff) begin
      quiet <= quiet + 8'h01;
    end
  end
  // data phase of a status read
  always_ff @(posedge clk) begin
    rd_status <= !rst && hsel && hready && htrans[1] && !hwrite && haddr == 32'h0;
  end
  // ==========
  // assertions
  a_pin_resets: assert property (
    (!pin_reset_n && !pin_reset_disable_fuse) [*8] |-> port_reset)
    else $error("pin held low without reset");
  a_power_drop: assert property ((!power_ok) [*6] |-> port_reset)
    else $error("supply drop without reset");
  a_low_supply: assert property (
    (!low_supply_ok && low_supply_level_fuse != 3'h0) [*6] |-> port_reset)
    else $error("low supply without reset");
  a_core_covers_port: assert property (port_reset |=> core_reset)
    else $error("core runs while a source is active");
  a_stretch_count: assert property (
    $fell(core_reset) && startup_time_fuse == 4'h0 |-> quiet >= 8'h10)
    else $error("core released before the delay count");
  a_dog_pulse_width: assert property (
    calm > 5'h08 && $rose(port_reset) |=> !port_reset)
    else $error("dog reset pulse longer than one cycle");
  a_irq_no_reset: assert property (
    calm > 5'h08 && $rose(dog_irq) |-> !port_reset ##1 !port_reset)
    else $error("dog request came with a reset");
  a_bandgap_fuse: assert property (
    $past(low_supply_level_fuse) != 3'h0 |-> bandgap_enable)
    else $error("bandgap off with detector enabled");
  a_status_upper_zero: assert property (rd_status |-> hrdata[31:4] == 28'h0)
    else $error("unused status bits read nonzero");
  c_dog_irq: cover property ($rose(dog_irq));
  c_release: cover property ($fell(core_reset));
  c_dog_pulse: cover property (calm > 5'h08 && $rose(port_reset));
endmodule : rwc_reset_ctrl_checker

bind rwc_reset_ctrl rwc_reset_ctrl_checker u_chk (.clk, .rst, .power_ok, .pin_reset_n,
  .low_supply_ok, .pin_reset_disable_fuse, .low_supply_level_fuse, .startup_time_fuse,
  .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .port_reset, .core_reset,
  .dog_irq, .bandgap_enable);

// ==== pkg/rwc_cfg.svh ====
/*
  Offsets, field positions, reset values and timing counts of the reset and
  watchdog control block. Assumes inclusion by bare name from design files.
*/
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

// ==========================================================================
// register offsets (byte addresses on the ahb-lite bus)
`define RWC_OFS_STATUS 12'h000
`define RWC_OFS_DOG_CTRL 12'h004
`define RWC_OFS_CONFIG 12'h008
`define RWC_OFS_RUN 12'h00c

// ==========================================================================
// status field positions
`define RWC_BIT_POWER_UP 0
`define RWC_BIT_PIN 1
`define RWC_BIT_LOW_SUPPLY 2
`define RWC_BIT_DOG 3

// ==========================================================================
// watchdog control field positions
`define RWC_BIT_DOG_IRQ_FLAG 7
`define RWC_BIT_DOG_IRQ_EN 6
`define RWC_BIT_DOG_UNLOCK 4
`define RWC_BIT_DOG_RST_EN 3

// ==========================================================================
// config field positions
`define RWC_BIT_CMP_BG_SEL 0
`define RWC_BIT_ADC_EN 1

// ==========================================================================
// timing
`define RWC_CLK_MHZ 125
`define RWC_DOG_OSC_KHZ 128
`define RWC_UNLOCK_CYCLES 3'h4
`define RWC_STATUS_RESET 8'h00
`define RWC_DOG_CTRL_RESET 8'h00
// synchroniser lanes after rst: power absent, pin high, supply good, tick low
`define RWC_SYNC_IDLE 4'h6
`endif

// ==== pkg/rwc_pkg.sv ====
/*
  Types of the reset and watchdog control block.
  Assumes rwc_cfg.svh holds the numbers.
*/
package rwc_pkg;
  // ========================================================================
  // internal reset sequencer states
  typedef enum logic [1:0] {
    RWC_HOLD = 2'b00,
    RWC_STRETCH = 2'b01,
    RWC_RUN = 2'b10
  } rwc_state_t;

  // watchdog action modes
  typedef enum logic [1:0] {
    RWC_DOG_STOP = 2'b00,
    RWC_DOG_IRQ = 2'b01,
    RWC_DOG_RST = 2'b10,
    RWC_DOG_BOTH = 2'b11
  } rwc_dog_mode_t;
endpackage : rwc_pkg

// ==== rtl/rwc_reset_ctrl.sv ====
/*
  Reset sequencer, reset cause status and watchdog of the controller.
  Assumes: the analog detectors and the pin arrive asynchronously; the core
  pulses dog_restart for its restart instruction; fuses are static levels.
*/
`timescale 1ns/1ps
`include "rwc_cfg.svh"

// Operation
// - reset loads registers, restarts at vector
// - ports reset immediately, needing no clock; here port_reset is registered on clk
// - stretch reset by fuse-set delay count
// - four sources combine into internal reset
// - long low pin resets; rise starts delay
// - disable fuse masks the pin source
// - power-on reasserts at once, rise delays
// - enabled low-supply detector resets at once
// - dog reset pulse one cycle wide
// - dog flag bit 3, cleared power-on/zero
// - low-supply flag bit 2, same clearing
// - pin flag bit 1, same clearing
// - power-up flag bit 0, zero-write only
// - status bits 7..4 read zero
// - bandgap on for detector, comparator, adc
// - dog counts 128 khz ticks, 16ms-8s
// - restart clears dog counter
// - interrupt mode raises wakeable request only
// - combined mode: interrupt then reset mode
// - always-on fuse forces reset mode
// - timed unlock sequence for dog changes
// - unlock bit self-clears after four cycles
// - dog flag forces reset-enable high
module rwc_reset_ctrl
  import rwc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic power_ok,
  input wire logic pin_reset_n,
  input wire logic low_supply_ok,
  input wire logic pin_reset_disable_fuse,
  input wire logic [2:0] low_supply_level_fuse,
  input wire logic [3:0] startup_time_fuse,
  input wire logic dog_always_on_fuse,
  input wire logic dog_osc_tick,
  input wire logic dog_restart,
  input wire logic dog_irq_ack,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic port_reset,
  output logic core_reset,
  output logic dog_irq,
  output logic bandgap_enable
);

  // ========================================================================
  // source synchronisers: three stages per lane, change counts when stages 2
  // and 3 agree; a lone metastable sample never reaches the reset logic
  localparam logic [3:0] sync_idle = `RWC_SYNC_IDLE;
  logic [3:0] sync_in;
  wire logic [3:0] sync_lvl;
  logic por_ok, pin_hi, bod_ok, tick_lvl, tick_prev;

  // lane order: power, pin, low supply, dog oscillator
  assign sync_in = {dog_osc_tick, low_supply_ok, pin_reset_n, power_ok};

  // rst parks every lane at a known level with power absent, so the
  // sequencer holds; without it the first cycles after rst see unknowns
  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    logic [2:0] stage;
    logic lvl;
    always_ff @(posedge clk) begin
      if (rst) begin
        stage <= {3{sync_idle[gi]}};
        lvl <= sync_idle[gi];
      end else begin
        stage <= {stage[1:0], sync_in[gi]};
        if (stage[1] == stage[2]) lvl <= stage[2];
      end
    end
    assign sync_lvl[gi] = lvl;
  end

  assign por_ok = sync_lvl[0];
  assign pin_hi = sync_lvl[1];
  assign bod_ok = sync_lvl[2];
  assign tick_lvl = sync_lvl[3];

  // tick edge detector parks low, the idle level of its lane, so rst
  // release cannot fake an oscillator tick
  always_ff @(posedge clk) begin
    if (rst) tick_prev <= 1'b0;
    else tick_prev <= tick_lvl;
  end

  logic bod_on;
  logic src_por, src_pin, src_bod, dog_pulse;
  assign bod_on = |low_supply_level_fuse;
  assign src_por = ~por_ok;
  assign src_pin = ~pin_hi & ~pin_reset_disable_fuse;
  assign src_bod = bod_on & ~bod_ok;

  // ========================================================================
  // reset sequencer
  logic any_src;
  logic [19:0] delay_cnt;
  logic [19:0] delay_target;
  rwc_state_t state;
  assign any_src = src_por | src_pin | src_bod | dog_pulse;

  // fuse code picks a power-of-two stretch; a long delay protects supply settling
  assign delay_target = 20'h00010 << startup_time_fuse;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= RWC_HOLD;
      delay_cnt <= 20'h00000;
    end else if (any_src) begin
      state <= RWC_HOLD;
      delay_cnt <= 20'h00000;
    end else begin
      unique case (state)
        RWC_HOLD: begin
          state <= RWC_STRETCH;
          delay_cnt <= 20'h00000;
        end
        RWC_STRETCH: begin
          delay_cnt <= delay_cnt + 20'h00001;
          if (delay_cnt >= delay_target) state <= RWC_RUN;
        end
        RWC_RUN: state <= RWC_RUN;
        default: state <= RWC_HOLD;
      endcase
    end
  end

  // port reset follows sources without waiting for the stretch; registered
  // here, the asynchronous path to pads belongs to the analog wrapper
  always_ff @(posedge clk) begin
    if (rst) begin
      port_reset <= 1'b1;
      core_reset <= 1'b1;
    end else begin
      port_reset <= any_src;
      core_reset <= any_src | (state != RWC_RUN);
    end
  end

  // ========================================================================
  // ahb-lite slave, zero wait states, always okay
  logic dp_wr;
  logic [11:0] dp_addr;
  logic ap_take;
  assign ap_take = hsel & hready & htrans[1];

  // reads are answered from the address phase, so only writes need a data phase latch
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_wr <= 1'b0;
      dp_addr <= 12'h000;
    end else begin
      dp_wr <= ap_take & hwrite;
      dp_addr <= haddr[11:0];
    end
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_status, wr_dog, wr_cfg;
  assign wr_status = dp_wr & hit(dp_addr, `RWC_OFS_STATUS);
  assign wr_dog = dp_wr & hit(dp_addr, `RWC_OFS_DOG_CTRL);
  assign wr_cfg = dp_wr & hit(dp_addr, `RWC_OFS_CONFIG);

  // ========================================================================
  // reset cause status; set beats a same-cycle zero write
  logic [3:0] cause;
  always_ff @(posedge clk) begin
    if (rst) begin
      cause <= 4'(`RWC_STATUS_RESET);
    end else if (src_por) begin
      cause <= 4'h1;
    end else begin
      cause[`RWC_BIT_DOG] <= dog_pulse |
        (cause[`RWC_BIT_DOG] & ~(wr_status & ~hwdata[`RWC_BIT_DOG]));
      cause[`RWC_BIT_LOW_SUPPLY] <= src_bod |
        (cause[`RWC_BIT_LOW_SUPPLY] & ~(wr_status & ~hwdata[`RWC_BIT_LOW_SUPPLY]));
      cause[`RWC_BIT_PIN] <= src_pin |
        (cause[`RWC_BIT_PIN] & ~(wr_status & ~hwdata[`RWC_BIT_PIN]));
      cause[`RWC_BIT_POWER_UP] <= cause[`RWC_BIT_POWER_UP] &
        ~(wr_status & ~hwdata[`RWC_BIT_POWER_UP]);
    end
  end

  // ========================================================================
  // analog config and bandgap enable
  logic cmp_bg_sel, adc_en;
  always_ff @(posedge clk) begin
    if (rst | core_reset) begin
      cmp_bg_sel <= 1'b0;
      adc_en <= 1'b0;
    end else if (wr_cfg) begin
      cmp_bg_sel <= hwdata[`RWC_BIT_CMP_BG_SEL];
      adc_en <= hwdata[`RWC_BIT_ADC_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) bandgap_enable <= 1'b0;
    else bandgap_enable <= bod_on | cmp_bg_sel | adc_en;
  end

  // ========================================================================
  // watchdog control register
  logic dog_rst_en, dog_irq_en, dog_unlock, dog_irq_flag;
  logic [3:0] dog_prescale_select;
  logic [2:0] unlock_cnt;
  logic dog_expire;
  logic unlock_req;
  assign unlock_req = wr_dog & hwdata[`RWC_BIT_DOG_UNLOCK] & hwdata[`RWC_BIT_DOG_RST_EN];

  // the unlock window counts cycles since it opened; the change must land inside
  always_ff @(posedge clk) begin
    if (rst | core_reset) begin
      dog_unlock <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (unlock_req) begin
      dog_unlock <= 1'b1;
      unlock_cnt <= 3'h0;
    end else if (dog_unlock) begin
      unlock_cnt <= unlock_cnt + 3'h1;
      if (unlock_cnt == `RWC_UNLOCK_CYCLES - 3'h1 || wr_dog) dog_unlock <= 1'b0;
    end
  end

  logic change_ok;
  assign change_ok = wr_dog & dog_unlock & ~hwdata[`RWC_BIT_DOG_UNLOCK];

  always_ff @(posedge clk) begin
    if (rst | core_reset) begin
      dog_rst_en <= 1'b0;
      dog_irq_en <= 1'b0;
      dog_prescale_select <= 4'h0;
    end else begin
      if (dog_always_on_fuse) begin
        dog_rst_en <= 1'b1;
        dog_irq_en <= 1'b0;
      end else begin
        if (cause[`RWC_BIT_DOG]) dog_rst_en <= 1'b1;
        else if (change_ok) dog_rst_en <= hwdata[`RWC_BIT_DOG_RST_EN];
        else if (wr_dog && hwdata[`RWC_BIT_DOG_RST_EN]) dog_rst_en <= 1'b1;
        // first expiry in combined mode drops to plain reset mode
        if (dog_expire && dog_irq_en && dog_rst_en) dog_irq_en <= 1'b0;
        else if (wr_dog) dog_irq_en <= hwdata[`RWC_BIT_DOG_IRQ_EN];
      end
      if (change_ok) dog_prescale_select <= {hwdata[5], hwdata[2:0]};
    end
  end

  // interrupt flag: expiry beats a same-cycle clear by write-one or ack
  always_ff @(posedge clk) begin
    if (rst | core_reset) dog_irq_flag <= 1'b0;
    else if (dog_expire && dog_irq_en) dog_irq_flag <= 1'b1;
    else if ((wr_dog && hwdata[`RWC_BIT_DOG_IRQ_FLAG]) || dog_irq_ack) dog_irq_flag <= 1'b0;
  end

  // request follows the flag alone: in combined mode the first expiry drops
  // the enable in the same cycle that it raises the flag
  always_ff @(posedge clk) begin
    if (rst) dog_irq <= 1'b0;
    else dog_irq <= dog_irq_flag;
  end

  // ========================================================================
  // watchdog counter on oscillator ticks; 2048 ticks is 16ms, doubling to 8s
  logic [19:0] dog_cnt;
  logic [19:0] dog_limit;
  logic dog_running;
  assign dog_limit = (20'h00800 << dog_prescale_select) - 20'h00001;
  assign dog_running = dog_rst_en | dog_irq_en;
  assign dog_expire = dog_running & (tick_lvl & ~tick_prev) & (dog_cnt >= dog_limit);

  always_ff @(posedge clk) begin
    if (rst | core_reset) dog_cnt <= 20'h00000;
    else if (dog_restart || !dog_running) dog_cnt <= 20'h00000;
    else if (tick_lvl & ~tick_prev) begin
      if (dog_cnt >= dog_limit) dog_cnt <= 20'h00000;
      else dog_cnt <= dog_cnt + 20'h00001;
    end
  end

  // one-cycle reset pulse; irq-only mode never resets
  always_ff @(posedge clk) begin
    if (rst) dog_pulse <= 1'b0;
    else dog_pulse <= dog_expire & dog_rst_en & ~dog_irq_en;
  end

  // ========================================================================
  // read mux; status bits 7..4 read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      if (ap_take && !hwrite) begin
        if (hit(haddr[11:0], `RWC_OFS_STATUS)) hrdata <= {28'h0000000, cause};
        else if (hit(haddr[11:0], `RWC_OFS_DOG_CTRL))
          hrdata <= {24'h000000, dog_irq_flag, dog_irq_en, dog_prescale_select[3], dog_unlock,
                     dog_rst_en, dog_prescale_select[2:0]};
        else if (hit(haddr[11:0], `RWC_OFS_CONFIG)) hrdata <= {30'h0, adc_en, cmp_bg_sel};
        else if (hit(haddr[11:0], `RWC_OFS_RUN)) hrdata <= {30'h0, state};
      end
    end
  end

endmodule : rwc_reset_ctrl
